// ==== logic/tfr_pkg.sv ====
// field layout and reset values for the typed field register bank
// ==========================================================================
// What this block does
// - read/write field returns last stored value; either side may update
// - read-only field loaded by hardware only; software writes ignored
// - write-only field feeds hardware; its read value is arbitrary
// - write-only field feeds hardware and always reads as zero
// - write-to-clear field: writing one clears the bit, zero leaves it
// - read-to-clear field holds hardware value until read, then clears to zero
// - one-to-clear field cleared by a one from software or hardware
// - constant-zero bits read zero and ignore writes
// - constant-one bits read one and ignore writes
// - absent bits ignore writes and read an arbitrary value
// - nonzero must-be-zero field raises a reserved-operand exception
// - bit zero is the least significant, rightmost position
package tfr_pkg;

	// ======================================================================
	// register geometry
	localparam int TFR_DATA_W = 32;

	// ======================================================================
	// field positions, low bit and width
	localparam int TFR_RW_LSB = 0;
	localparam int TFR_RW_W = 4;
	localparam int TFR_RO_LSB = 4;
	localparam int TFR_RO_W = 3;
	localparam int TFR_WO_LSB = 7;
	localparam int TFR_WO_W = 4;
	localparam int TFR_WOZ_LSB = 11;
	localparam int TFR_WOZ_W = 4;
	localparam int TFR_WC_LSB = 15;
	localparam int TFR_WC_W = 4;
	localparam int TFR_RC_LSB = 19;
	localparam int TFR_RC_W = 4;
	localparam int TFR_W1C_LSB = 23;
	localparam int TFR_W1C_W = 4;
	localparam int TFR_ZERO_BIT = 27;
	localparam int TFR_ONE_BIT = 28;
	localparam int TFR_ABSENT_BIT = 29;
	localparam int TFR_HINT_BIT = 30;
	localparam int TFR_MUST_ZERO_BIT = 31;

	// ======================================================================
	// values after reset
	localparam logic [3:0] TFR_RW_RST = 4'h0;
	localparam logic [3:0] TFR_WO_RST = 4'h0;
	localparam logic [3:0] TFR_WOZ_RST = 4'h0;
	localparam logic [2:0] TFR_RO_RST = 3'h0;
	localparam logic [3:0] TFR_WC_RST = 4'h0;
	localparam logic [3:0] TFR_RC_RST = 4'h0;
	localparam logic [3:0] TFR_W1C_RST = 4'h0;
	localparam logic TFR_EXC_RST = 1'b0;
	localparam logic [31:0] TFR_RDATA_RST = 32'h00000000;

endpackage : tfr_pkg

// ==== logic/tfr_reg_bank.sv ====
// typed field register bank with processor and hardware sides
`timescale 1ns/100ps

module tfr_reg_bank
	import tfr_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// processor transaction side
	input wire logic i_wr_en,
	input wire logic [31:0] i_wdata,
	input wire logic i_rd_en,
	output logic [31:0] o_rdata,
	output logic o_rd_valid,
	output logic o_resop_exc,
	// hardware side inputs
	input wire logic i_hw_rw_we,
	input wire logic [3:0] i_hw_rw_data,
	input wire logic [2:0] i_ro_status,
	input wire logic [3:0] i_wc_set,
	input wire logic i_rc_load,
	input wire logic [3:0] i_rc_data,
	input wire logic [3:0] i_w1c_set,
	input wire logic [3:0] i_w1c_hw_clr,
	// hardware side outputs
	output logic [3:0] o_rw_field,
	output logic [3:0] o_wo_field,
	output logic [3:0] o_woz_field,
	output logic o_rc_full
);

	// ======================================================================
	// field extraction, bit zero is the rightmost position
	// little-end numbering
	function automatic logic [3:0] fld4(input logic [31:0] w, input int lsb);
		fld4 = w[lsb +: 4];
	endfunction

	logic wr_ok;
	logic [3:0] wr_rw;
	logic [3:0] wr_wo;
	logic [3:0] wr_woz;
	logic [3:0] wr_wc;
	logic [3:0] wr_w1c;
	logic [2:0] ro_q;
	logic [3:0] wc_q;
	logic [3:0] rc_q;
	logic [3:0] w1c_q;
	logic [31:0] next_rdata;

	// ======================================================================
	// write qualification
	// trap on must-be-zero
	// a faulting write is dropped whole, as an operand fault aborts the store
	assign wr_ok = i_wr_en && !i_wdata[TFR_MUST_ZERO_BIT];
	assign wr_rw = fld4(i_wdata, TFR_RW_LSB);
	assign wr_wo = fld4(i_wdata, TFR_WO_LSB);
	assign wr_woz = fld4(i_wdata, TFR_WOZ_LSB);
	assign wr_wc = fld4(i_wdata, TFR_WC_LSB);
	assign wr_w1c = fld4(i_wdata, TFR_W1C_LSB);

	// reserved-operand exception pulse, one cycle after the bad write
	// exception pulse
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			o_resop_exc <= TFR_EXC_RST;
		else
			o_resop_exc <= i_wr_en && i_wdata[TFR_MUST_ZERO_BIT];
	end

	// ======================================================================
	// read/write field, processor write wins over hardware load
	// stored value
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			o_rw_field <= TFR_RW_RST;
		else if (wr_ok)
			o_rw_field <= wr_rw;
		else if (i_hw_rw_we)
			o_rw_field <= i_hw_rw_data;
	end

	// read-only field follows hardware status, writes never reach it
	// hardware only
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			ro_q <= TFR_RO_RST;
		else
			ro_q <= i_ro_status;
	end

	// write-only fields, both feed hardware
	// undefined-read store
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_wo_field <= TFR_WO_RST;
			o_woz_field <= TFR_WOZ_RST;
		end
		else if (wr_ok)
		begin
			o_wo_field <= wr_wo;
			o_woz_field <= wr_woz;
		end
	end

	// ======================================================================
	// write-to-clear flags; a set in the clearing cycle is kept
	// one clears
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			wc_q <= TFR_WC_RST;
		else if (wr_ok)
			wc_q <= (wc_q & ~wr_wc) | i_wc_set;
		else
			wc_q <= wc_q | i_wc_set;
	end

	// one-to-clear flags, cleared by processor or hardware ones, set wins
	// either side clears
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			w1c_q <= TFR_W1C_RST;
		else if (wr_ok)
			w1c_q <= (w1c_q & ~(wr_w1c | i_w1c_hw_clr)) | i_w1c_set;
		else
			w1c_q <= (w1c_q & ~i_w1c_hw_clr) | i_w1c_set;
	end

	// read-to-clear: held until read; a load in the read cycle is taken
	// because the read already returns the old value
	// hold until read
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			rc_q <= TFR_RC_RST;
			o_rc_full <= 1'b0;
		end
		else if (i_rc_load && (!o_rc_full || i_rd_en))
		begin
			rc_q <= i_rc_data;
			o_rc_full <= 1'b1;
		end
		else if (i_rd_en)
		begin
			rc_q <= 4'h0;
			o_rc_full <= 1'b0;
		end
	end

	// ======================================================================
	// read word assembly
	always_comb
	begin
		next_rdata = TFR_RDATA_RST;
		next_rdata[TFR_RW_LSB +: TFR_RW_W] = o_rw_field;
		next_rdata[TFR_RO_LSB +: TFR_RO_W] = ro_q;
		next_rdata[TFR_WO_LSB +: TFR_WO_W] = o_wo_field;
		next_rdata[TFR_WOZ_LSB +: TFR_WOZ_W] = 4'h0;
		next_rdata[TFR_WC_LSB +: TFR_WC_W] = wc_q;
		next_rdata[TFR_RC_LSB +: TFR_RC_W] = rc_q;
		next_rdata[TFR_W1C_LSB +: TFR_W1C_W] = w1c_q;
		next_rdata[TFR_ZERO_BIT] = 1'b0;
		next_rdata[TFR_ONE_BIT] = 1'b1;
		next_rdata[TFR_ABSENT_BIT] = 1'b0;
		// reserved hint and must-be-zero bits have no storage
		next_rdata[TFR_HINT_BIT] = 1'b0;
		next_rdata[TFR_MUST_ZERO_BIT] = 1'b0;
	end

	// read answer one cycle after the request
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_rdata <= TFR_RDATA_RST;
			o_rd_valid <= 1'b0;
		end
		else
		begin
			o_rd_valid <= i_rd_en;
			if (i_rd_en)
				o_rdata <= next_rdata;
		end
	end

	// ======================================================================
	// checks
	// write then read back
	property p_rw_store;
		@(posedge i_ref_clk) disable iff (i_srst)
		wr_ok |=> o_rw_field == $past(i_wdata[3:0]);
	endproperty
	a_rw_store: assert property (p_rw_store)
		else $error("rw field did not take the write");

	property p_ro_hw;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_rd_en && !$past(i_srst) |=> o_rdata[6:4] == $past(i_ro_status, 2);
	endproperty
	a_ro_hw: assert property (p_ro_hw)
		else $error("ro field not from hardware status");

	property p_woz_zero;
		@(posedge i_ref_clk) disable iff (i_srst)
		o_rd_valid |-> o_rdata[14:11] == 4'h0;
	endproperty
	a_woz_zero: assert property (p_woz_zero)
		else $error("zero-read write-only field read nonzero");

	property p_wc_clear;
		@(posedge i_ref_clk) disable iff (i_srst)
		wr_ok && i_wc_set == 4'h0 |=> wc_q == ($past(wc_q) & ~$past(wr_wc));
	endproperty
	a_wc_clear: assert property (p_wc_clear)
		else $error("wc field wrong after write");

	property p_rc_hold;
		@(posedge i_ref_clk) disable iff (i_srst)
		o_rc_full && !i_rd_en |=> $stable(rc_q) && o_rc_full;
	endproperty
	a_rc_hold: assert property (p_rc_hold)
		else $error("rc field changed before read");

	property p_w1c_hw;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_w1c_hw_clr[0] && !i_w1c_set[0] |=> !w1c_q[0];
	endproperty
	a_w1c_hw: assert property (p_w1c_hw)
		else $error("w1c bit not cleared by hardware");

	property p_const_bits;
		@(posedge i_ref_clk) disable iff (i_srst)
		o_rd_valid |-> !o_rdata[27] && o_rdata[28];
	endproperty
	a_const_bits: assert property (p_const_bits)
		else $error("constant bits read wrong");

	property p_resop_trap;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_wr_en && i_wdata[31] && !i_hw_rw_we
		|=> o_resop_exc && $stable(o_rw_field) && $stable(o_woz_field);
	endproperty
	a_resop_trap: assert property (p_resop_trap)
		else $error("must-be-zero write not trapped");

	// read answer carries the held value
	property p_rd_answer;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_rd_en |=> o_rd_valid && o_rdata[22:19] == $past(rc_q);
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer out of step");

	// both write-only fields of one write land together
	property p_wr_fields;
		@(posedge i_ref_clk) disable iff (i_srst)
		wr_ok |=> o_wo_field == $past(wr_wo)
			&& o_woz_field == $past(wr_woz);
	endproperty
	a_wr_fields: assert property (p_wr_fields)
		else $error("write-only fields did not take the write");

	property p_rw_hw;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_hw_rw_we && !wr_ok |=> o_rw_field == $past(i_hw_rw_data);
	endproperty
	a_rw_hw: assert property (p_rw_hw)
		else $error("rw field did not take the hardware load");

	property p_w1c_sw;
		@(posedge i_ref_clk) disable iff (i_srst)
		wr_ok && i_w1c_set == 4'h0 |=> (w1c_q & $past(wr_w1c)) == 4'h0;
	endproperty
	a_w1c_sw: assert property (p_w1c_sw)
		else $error("one-to-clear bits not cleared by a write");

	property p_rc_read;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_rd_en && !i_rc_load |=> !o_rc_full && rc_q == 4'h0;
	endproperty
	a_rc_read: assert property (p_rc_read)
		else $error("rc field not emptied by a read");

endmodule // tfr_reg_bank

// ==== test/tfr_cpu_model.sv ====
// processor-side model issuing register reads and writes
`timescale 1ns/100ps

module tfr_cpu_model
(
	// clock
	input wire logic i_ref_clk,
	// answer from the bank
	input wire logic [31:0] i_rdata,
	input wire logic i_rd_valid,
	// requests to the bank
	output logic o_wr_en,
	output logic [31:0] o_wdata,
	output logic o_rd_en
);

	// idle requests from time zero
	initial
	begin
		o_wr_en = 1'b0;
		o_wdata = 32'h0;
		o_rd_en = 1'b0;
	end

	// ======================================================================
	// write: one pulse, data held across the taking edge
	// reserved bits zero unless a refusal is wanted
	task automatic write(input logic [31:0] w, input logic bad);
		@(negedge i_ref_clk);
		o_wr_en = 1'b1;
		o_wdata = {bad, 1'b0, w[29:0]};
		@(negedge i_ref_clk);
		o_wr_en = 1'b0;
		// released bus shows junk, not the old word
		o_wdata = ~o_wdata;
	endtask

	// ======================================================================
	// read: one pulse, answer polled for a few cycles only
	task automatic read(output logic [31:0] d, output logic ok);
		int n;
		@(negedge i_ref_clk);
		o_rd_en = 1'b1;
		@(negedge i_ref_clk);
		o_rd_en = 1'b0;
		ok = 1'b0;
		d = 32'h0;
		for (n = 0; n < 4 && !ok; n++)
		begin
			if (i_rd_valid === 1'b1)
			begin
				ok = 1'b1;
				d = i_rdata;
			end
			else
				@(negedge i_ref_clk);
		end
	endtask

endmodule // tfr_cpu_model

// ==== test/tfr_reg_bank_bench.sv ====
// self-checking bench for the typed field register bank
`timescale 1ns/100ps

module tfr_reg_bank_bench;

	// ======================================================================
	// signals and expected state
	logic ref_clk, srst, wr_en, rd_en, rd_valid, resop_exc, hw_rw_we;
	logic rc_load, rc_full, e_full;
	logic [31:0] wdata, rdata;
	logic [3:0] hw_rw_data, wc_set, rc_data, w1c_set, w1c_hw_clr;
	logic [3:0] rw_f, wo_f, woz_f, e_rw, e_wo, e_woz, e_wc, e_rc, e_w1c;
	logic [2:0] ro_status;
	int failures, n_tests;

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	tfr_reg_bank dut (.i_ref_clk(ref_clk), .i_srst(srst), .i_wr_en(wr_en),
		.i_wdata(wdata), .i_rd_en(rd_en), .o_rdata(rdata),
		.o_rd_valid(rd_valid), .o_resop_exc(resop_exc),
		.i_hw_rw_we(hw_rw_we),
		.i_hw_rw_data(hw_rw_data), .i_ro_status(ro_status),
		.i_wc_set(wc_set), .i_rc_load(rc_load), .i_rc_data(rc_data),
		.i_w1c_set(w1c_set), .i_w1c_hw_clr(w1c_hw_clr), .o_rw_field(rw_f),
		.o_wo_field(wo_f), .o_woz_field(woz_f), .o_rc_full(rc_full));

	tfr_cpu_model u_cpu (.i_ref_clk(ref_clk), .i_rdata(rdata),
		.i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_wdata(wdata),
		.o_rd_en(rd_en));

	// ======================================================================
	// comparison, verdict and expectation
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// read word: must-zero, hint, absent, one, zero, then typed fields
	function automatic logic [31:0] exp_word();
		return {3'h0, 1'b1, 1'b0, e_w1c, e_rc, e_wc, 4'h0, e_wo, ro_status,
			e_rw};
	endfunction

	// ======================================================================
	// hardware side: set, clear, load pulses for one cycle
	task automatic hw_pulse(input logic [3:0] v);
		logic [3:0] s, c;
		s = 4'($urandom);
		c = 4'($urandom);
		@(negedge ref_clk);
		{wc_set, w1c_set, w1c_hw_clr, rc_data} = {s, s, c, v};
		{rc_load, hw_rw_we, hw_rw_data, ro_status} = {2'h3, ~v, v[2:0]};
		@(negedge ref_clk);
		{wc_set, w1c_set, w1c_hw_clr, rc_load, hw_rw_we} = 14'h0;
		e_wc = e_wc | s;
		e_w1c = (e_w1c & ~c) | s;
		e_rw = ~v;
		// a load while full must be dropped
		if (!e_full)
			{e_rc, e_full} = {v, 1'b1};
		@(negedge ref_clk);
		check(rw_f, e_rw);
		check(rc_full, e_full);
	endtask

	// ======================================================================
	// processor side write and read with checks
	task automatic wr_check(input logic [31:0] w, input logic bad);
		logic [1:0] cnt;
		logic hit;
		cnt = 2'h0;
		// hardware load racing the write: a good write must win
		hit = w[5];
		hw_rw_data = 4'($urandom);
		hw_rw_we = hit;
		u_cpu.write(w, bad);
		hw_rw_we = 1'b0;
		if (hit)
			e_rw = hw_rw_data;
		repeat (3)
		begin
			cnt = cnt + 2'(resop_exc === 1'b1);
			@(negedge ref_clk);
		end
		if (!bad)
		begin
			{e_rw, e_wo, e_woz} = {w[3:0], w[10:7], w[14:11]};
			e_wc = e_wc & ~w[18:15];
			e_w1c = e_w1c & ~w[26:23];
		end
		check(cnt, bad);
		check({rw_f, wo_f, woz_f}, {e_rw, e_wo, e_woz});
	endtask

	task automatic rd_check();
		logic [31:0] d;
		logic ok;
		u_cpu.read(d, ok);
		check(ok, 1'b1);
		if (!ok)
			complete_run();
		// absent bit 29 may read anything
		check(d[26:0], exp_word() & 32'h07FFFFFF);
		check(d[31:27] & 5'h1B, 5'h02);
		{e_rc, e_full} = 5'h0;
	endtask

	// ======================================================================
	// main sequence
	initial
	begin
		{srst, hw_rw_we, rc_load, hw_rw_data, wc_set, rc_data} = 15'h4000;
		{w1c_set, w1c_hw_clr, ro_status} = 11'h0;
		{e_rw, e_wo, e_woz, e_wc, e_rc, e_w1c, e_full} = 25'h0;
		failures = 0;
		n_tests = 0;
		void'($urandom(32'h3a7a0982));
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		srst = 1'b0;
		check(rdata, 32'h0);
		check({rw_f, wo_f, woz_f, rc_full}, 13'h0);
		rd_check();
		for (int i = 0; i < 24; i++)
		begin
			hw_pulse(4'($urandom));
			hw_pulse(4'($urandom));
			wr_check(i == 0 ? 32'hFFFFFFFF : $urandom, i % 4 == 3);
			rd_check();
		end
		complete_run();
	end

endmodule // tfr_reg_bank_bench
